// ==== hifdl_pkg.sv ====
package hifdl_pkg;
    // =========================================================
    // Sizes
    localparam int QUEUE_DEPTH    = 32;
    localparam int PREFETCH_DEPTH = 8;
    localparam int TAG_W          = 9;
    localparam int DATA_W         = 32;
    localparam int COUNT_W        = 16;
    localparam int ADDR_W         = 17;
    localparam int QCNT_W         = 6;
    localparam int ENTRY_W        = 41;

    // =========================================================
    // Control offsets inside the region
    localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h008;
    localparam logic [11:0] OFS_IRQ_PENDING = 12'h010;
    localparam logic [11:0] OFS_QUEUE_FREE  = 12'h018;
    localparam logic [11:0] OFS_XFER_BASE   = 12'h028;
    localparam logic [11:0] OFS_XFER_COUNT  = 12'h030;
    localparam logic [11:0] OFS_BUS_RETRY   = 12'h068;

    // =========================================================
    // Region decode on address bits 15:12
    localparam logic [3:0] AREA_CTRL   = 4'h0;
    localparam logic [3:0] AREA_WINDOW = 4'h2;
    localparam int         AREA_GP_BIT = 15;

    // =========================================================
    // Field positions
    localparam int RETRY_EN_BIT   = 0;
    localparam int DONE_BIT       = 0;
    localparam int DESC_MODE_LSB  = 14;
    localparam int DESC_COUNT_LSB = 16;
    localparam int GROUP_LSB      = 4;

    localparam logic [1:0] MODE_HOLD  = 2'h0;
    localparam logic [1:0] MODE_INCR  = 2'h1;
    localparam logic [1:0] MODE_INDEX = 2'h2;

    // =========================================================
    // Reset values
    localparam logic [31:0]        RST_BASE  = 32'h0;
    localparam logic [COUNT_W-1:0] RST_COUNT = 16'h0;
    localparam logic               RST_RETRY = 1'b0;
    localparam logic               RST_IRQEN = 1'b0;
    localparam logic [31:0]        WORD_STEP = 32'h4;
endpackage

// ==== hifdl_fifo.sv ====
`timescale 1ns/100ps
module hifdl_fifo
    import hifdl_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int CW    = $clog2(DEPTH + 1)
)
(
    // Clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             nrst_in,
    // Filling side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // Draining side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in,
    // Fill level
    output logic [CW-1:0]         count_out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [CW-1:0]               cnt;
    } hifdl_fifo_state_t;

    hifdl_fifo_state_t s_reg;
    hifdl_fifo_state_t s_next;
    logic              push;
    logic              pop;

    assign in_ready_out  = (s_reg.cnt != CW'(DEPTH));
    assign out_valid_out = (s_reg.cnt != '0);
    assign out_data_out  = s_reg.mem[s_reg.rd];
    assign count_out     = s_reg.cnt;

    always_comb
    begin
        s_next = s_reg;
        push   = in_valid_in && in_ready_out;
        pop    = out_valid_out && out_ready_in;
        if (push)
        begin
            s_next.mem[s_reg.wr] = in_data_in;
            s_next.wr = (s_reg.wr == LAST) ? '0 : s_reg.wr + 1'b1;
        end
        if (pop)
        begin
            s_next.rd = (s_reg.rd == LAST) ? '0 : s_reg.rd + 1'b1;
        end
        if (push && !pop)
        begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end
endmodule

// ==== hifdl_expander.sv ====
`timescale 1ns/100ps
module hifdl_expander
    import hifdl_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              nrst_in,
    // Word stream in
    input  wire logic              in_valid_in,
    input  wire logic              in_raw_in,
    input  wire logic [TAG_W-1:0]  in_tag_in,
    input  wire logic [DATA_W-1:0] in_data_in,
    output logic                   in_ready_out,
    // Tag/data entries out
    output logic                   out_valid_out,
    output logic [TAG_W-1:0]       out_tag_out,
    output logic [DATA_W-1:0]      out_data_out,
    input  wire logic              out_ready_in
);
    typedef struct packed {
        logic               want_desc;
        logic [1:0]         mode;
        logic [TAG_W-1:0]   tag;
        logic [COUNT_W-1:0] left;
        logic [15:0]        mask;
    } hifdl_exp_state_t;

    hifdl_exp_state_t s_reg;
    hifdl_exp_state_t s_next;

    function automatic logic [3:0] low_bit(input logic [15:0] m);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 15; i >= 0; i--)
        begin
            if (m[i])
            begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    always_comb
    begin
        s_next        = s_reg;
        in_ready_out  = 1'b0;
        out_valid_out = 1'b0;
        out_tag_out   = in_tag_in;
        out_data_out  = in_data_in;
        if (!in_raw_in)
        begin
            out_valid_out = in_valid_in;
            in_ready_out  = out_ready_in;
        end
        else if (s_reg.want_desc)
        begin
            in_ready_out = 1'b1;
            if (in_valid_in)
            begin
                s_next.mode = in_data_in[DESC_MODE_LSB +: 2];
                s_next.tag  = in_data_in[TAG_W-1:0];
                s_next.left = in_data_in[DESC_COUNT_LSB +: COUNT_W];
                s_next.mask = in_data_in[DESC_COUNT_LSB +: 16];
                s_next.want_desc = (s_next.mode == MODE_INDEX) &&
                                   (s_next.mask == 16'h0);
            end
        end
        else
        begin
            out_valid_out = in_valid_in;
            in_ready_out  = out_ready_in;
            if (s_reg.mode == MODE_INDEX)
            begin
                out_tag_out = {s_reg.tag[TAG_W-1:GROUP_LSB],
                               low_bit(s_reg.mask)};
            end
            else
            begin
                out_tag_out = s_reg.tag;
            end
            if (in_valid_in && out_ready_in)
            begin
                if (s_reg.mode == MODE_INDEX)
                begin
                    s_next.mask = s_reg.mask &
                                  ~(16'h1 << low_bit(s_reg.mask));
                    s_next.want_desc = (s_next.mask == 16'h0);
                end
                else
                begin
                    s_next.left = s_reg.left - 1'b1;
                    s_next.want_desc = (s_reg.left == '0);
                    if (s_reg.mode == MODE_INCR)
                    begin
                        s_next.tag = s_reg.tag + 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s_reg <= '{want_desc: 1'b1, default: '0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end
endmodule

// ==== hifdl_top.sv ====
`timescale 1ns/100ps
// How it works
// - Queue holds 32 tag/data entries.
// - Free-entry count never exceeds 32.
// - Count rises on removal, falls on insert.
// - Register write only enqueues a tag/data entry.
// - Full queue without retry drops the write.
// - Bit zero at 0x68 enables retry.
// - Full queue with retry answers disconnect.
// - Free count readable anytime, no side effects.
// - 4K window writes raw words into queue.
// - Window reads return no register contents.
// - Window accesses are aligned whole words.
// - Engine fetches buffers below 64K words.
// - Count write starts transfer from base.
// - Engine stalls while the prefetch buffer lacks room.
// - Base address latched at transfer start.
// - Engine only reads host memory.
// - Buffer is descriptor word plus data words.
// - One descriptor may carry many data words.
// - Count decrements per fetched word; zero done.
// - Descriptor: tag 8:0, mode, count-1 top.
// - Indexed mode masks registers within group.
// - Completion flag raised on count reaching zero.
module hifdl_top
    import hifdl_pkg::*;
#(
    parameter int QDEPTH = QUEUE_DEPTH,
    parameter int PDEPTH = PREFETCH_DEPTH
)
(
    // Clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              nrst_in,
    // Host target access
    input  wire logic              host_req_in,
    input  wire logic              host_we_in,
    input  wire logic [ADDR_W-1:0] host_addr_in,
    input  wire logic [DATA_W-1:0] host_wdata_in,
    output logic                   host_ack_out,
    output logic                   host_retry_out,
    output logic [DATA_W-1:0]      host_rdata_out,
    // Host memory read master
    output logic                   mem_rd_req_out,
    output logic [31:0]            mem_addr_out,
    input  wire logic              mem_rd_valid_in,
    input  wire logic [DATA_W-1:0] mem_rd_data_in,
    // Render core drain side
    output logic                   core_valid_out,
    output logic [TAG_W-1:0]       core_tag_out,
    output logic [DATA_W-1:0]      core_data_out,
    input  wire logic              core_ready_in,
    // Completion interrupt
    output logic                   irq_out
);
    localparam int PCW = $clog2(PDEPTH + 1);

    typedef struct packed {
        logic               ack;
        logic               retry;
        logic [DATA_W-1:0]  rdata;
        logic               retry_en;
        logic               irq_en;
        logic               done;
        logic               irq;
        logic [31:0]        base;
        logic [COUNT_W-1:0] count;
        logic [31:0]        addr;
        logic               rd_req;
        logic               head_valid;
        logic [TAG_W-1:0]   head_tag;
        logic [DATA_W-1:0]  head_data;
    } hifdl_state_t;

    hifdl_state_t s_reg;
    hifdl_state_t s_next;

    // =========================================================
    // Internal streams
    logic               exp_in_valid;
    logic               exp_in_raw;
    logic [DATA_W-1:0]  exp_in_data;
    logic               exp_in_ready;
    logic               exp_out_valid;
    logic [TAG_W-1:0]   exp_out_tag;
    logic [DATA_W-1:0]  exp_out_data;
    logic               q_in_ready;
    logic               q_out_valid;
    logic [ENTRY_W-1:0] q_out_data;
    logic               q_out_ready;
    logic [QCNT_W-1:0]  q_count;
    logic               pf_in_valid;
    logic               pf_in_ready;
    logic               pf_out_valid;
    logic [DATA_W-1:0]  pf_out_data;
    logic               pf_out_ready;
    logic [PCW-1:0]     pf_count;

    // Decode of the current host access
    logic              take;
    logic              in_ctrl;
    logic              in_win;
    logic              in_gp;
    logic              host_feed;
    logic [11:0]       ofs;
    logic [QCNT_W-1:0] free_entries;

    function automatic logic is_ctrl_write(input logic [11:0] o,
                                           input logic [11:0] want,
                                           input logic t,
                                           input logic we,
                                           input logic c);
        return t && we && c && (o == want);
    endfunction

    assign free_entries = QCNT_W'(QDEPTH) - q_count;
    assign take    = host_req_in && !s_reg.ack && !s_reg.retry;
    assign ofs     = host_addr_in[11:0];
    assign in_gp   = host_addr_in[AREA_GP_BIT];
    assign in_ctrl = !in_gp && (host_addr_in[15:12] == AREA_CTRL);
    assign in_win  = !in_gp && (host_addr_in[15:12] == AREA_WINDOW);
    // Window writes must be aligned words; others are ignored
    assign host_feed = take && host_we_in && (in_gp ||
                       (in_win && host_addr_in[1:0] == 2'b00));

    // =========================================================
    // Source selection into the expander; host has priority
    always_comb
    begin
        exp_in_valid = host_feed || pf_out_valid;
        exp_in_raw   = host_feed ? in_win : 1'b1;
        exp_in_data  = host_feed ? host_wdata_in : pf_out_data;
        pf_out_ready = !host_feed && exp_in_ready;
        pf_in_valid  = s_reg.rd_req && mem_rd_valid_in;
        q_out_ready  = !s_reg.head_valid || core_ready_in;
    end

    // =========================================================
    // Registers, transfer engine and host answers
    always_comb
    begin
        s_next       = s_reg;
        s_next.ack   = 1'b0;
        s_next.retry = 1'b0;

        // Host access answer
        if (host_feed)
        begin
            if (exp_in_ready)
            begin
                s_next.ack = 1'b1;
            end
            else if (s_reg.retry_en)
            begin
                s_next.retry = 1'b1;
            end
            else
            begin
                s_next.ack = 1'b1;
            end
        end
        else if (take)
        begin
            s_next.ack = 1'b1;
        end

        // Read data; non-control areas read zero
        if (take && !host_we_in)
        begin
            s_next.rdata = '0;
            if (in_ctrl)
            begin
                unique case (ofs)
                    OFS_QUEUE_FREE:
                        s_next.rdata = DATA_W'(free_entries);
                    OFS_BUS_RETRY:
                        s_next.rdata[RETRY_EN_BIT] = s_reg.retry_en;
                    OFS_IRQ_ENABLE:
                        s_next.rdata[DONE_BIT] = s_reg.irq_en;
                    OFS_IRQ_PENDING:
                        s_next.rdata[DONE_BIT] = s_reg.done;
                    OFS_XFER_BASE:
                        s_next.rdata = s_reg.base;
                    OFS_XFER_COUNT:
                        s_next.rdata = DATA_W'(s_reg.count);
                    default:
                        s_next.rdata = '0;
                endcase
            end
        end

        // Control writes
        if (is_ctrl_write(ofs, OFS_BUS_RETRY, take, host_we_in,
                          in_ctrl))
        begin
            s_next.retry_en = host_wdata_in[RETRY_EN_BIT];
        end
        if (is_ctrl_write(ofs, OFS_IRQ_ENABLE, take, host_we_in,
                          in_ctrl))
        begin
            s_next.irq_en = host_wdata_in[DONE_BIT];
        end
        if (is_ctrl_write(ofs, OFS_XFER_BASE, take, host_we_in,
                          in_ctrl))
        begin
            s_next.base = {host_wdata_in[31:2], 2'b00};
        end
        if (is_ctrl_write(ofs, OFS_IRQ_PENDING, take, host_we_in,
                          in_ctrl) && host_wdata_in[DONE_BIT])
        begin
            s_next.done = 1'b0;
        end

        // Fetch: one read outstanding, only into free prefetch room
        if (s_reg.rd_req && mem_rd_valid_in)
        begin
            s_next.rd_req = 1'b0;
            s_next.addr   = s_reg.addr + WORD_STEP;
            s_next.count  = s_reg.count - 1'b1;
            if (s_reg.count == COUNT_W'(1))
            begin
                s_next.done = 1'b1;
            end
        end
        else if (!s_reg.rd_req && s_reg.count != '0 && pf_in_ready)
        begin
            s_next.rd_req = 1'b1;
        end

        // Count write starts a transfer at the latched base
        if (is_ctrl_write(ofs, OFS_XFER_COUNT, take, host_we_in,
                          in_ctrl))
        begin
            s_next.count  = host_wdata_in[COUNT_W-1:0];
            s_next.addr   = s_reg.base;
            s_next.rd_req = 1'b0;
        end

        s_next.irq = s_next.done && s_next.irq_en;

        // Output stage towards the render core
        if (s_reg.head_valid && core_ready_in)
        begin
            s_next.head_valid = 1'b0;
        end
        if (q_out_valid && q_out_ready)
        begin
            s_next.head_valid = 1'b1;
            s_next.head_tag   = q_out_data[ENTRY_W-1:DATA_W];
            s_next.head_data  = q_out_data[DATA_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s_reg <= '{base: RST_BASE, count: RST_COUNT,
                       retry_en: RST_RETRY, irq_en: RST_IRQEN,
                       default: '0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // =========================================================
    // Outputs
    assign host_ack_out   = s_reg.ack;
    assign host_retry_out = s_reg.retry;
    assign host_rdata_out = s_reg.rdata;
    assign mem_rd_req_out = s_reg.rd_req;
    assign mem_addr_out   = s_reg.addr;
    assign core_valid_out = s_reg.head_valid;
    assign core_tag_out   = s_reg.head_tag;
    assign core_data_out  = s_reg.head_data;
    assign irq_out        = s_reg.irq;

    // =========================================================
    // Prefetch buffer for fetched words
    hifdl_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (PDEPTH),
        .CW    (PCW)
    ) u_prefetch (
        .clk_sys_in    (clk_sys_in),
        .nrst_in       (nrst_in),
        .in_valid_in   (pf_in_valid),
        .in_data_in    (mem_rd_data_in),
        .in_ready_out  (pf_in_ready),
        .out_valid_out (pf_out_valid),
        .out_data_out  (pf_out_data),
        .out_ready_in  (pf_out_ready),
        .count_out     (pf_count)
    );

    // =========================================================
    // Descriptor expansion into tag/data entries
    hifdl_expander u_expander (
        .clk_sys_in    (clk_sys_in),
        .nrst_in       (nrst_in),
        .in_valid_in   (exp_in_valid),
        .in_raw_in     (exp_in_raw),
        .in_tag_in     (host_addr_in[11:3]),
        .in_data_in    (exp_in_data),
        .in_ready_out  (exp_in_ready),
        .out_valid_out (exp_out_valid),
        .out_tag_out   (exp_out_tag),
        .out_data_out  (exp_out_data),
        .out_ready_in  (q_in_ready)
    );

    // =========================================================
    // Input queue
    hifdl_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (QDEPTH),
        .CW    (QCNT_W)
    ) u_queue (
        .clk_sys_in    (clk_sys_in),
        .nrst_in       (nrst_in),
        .in_valid_in   (exp_out_valid),
        .in_data_in    ({exp_out_tag, exp_out_data}),
        .in_ready_out  (q_in_ready),
        .out_valid_out (q_out_valid),
        .out_data_out  (q_out_data),
        .out_ready_in  (q_out_ready),
        .count_out     (q_count)
    );
endmodule

// ==== hifdl_checker_asserts.sv ====
`timescale 1ns/100ps
module hifdl_checker
    import hifdl_pkg::*;
#(
    parameter int QDEPTH = QUEUE_DEPTH
)
(
    // Clock and reset
    input wire logic              clk_sys_in,
    input wire logic              nrst_in,
    // Host side
    input wire logic              host_req_in,
    input wire logic              host_we_in,
    input wire logic [ADDR_W-1:0] host_addr_in,
    input wire logic              host_ack_out,
    input wire logic              host_retry_out,
    input wire logic [DATA_W-1:0] host_rdata_out,
    // Memory and core side
    input wire logic              mem_rd_req_out,
    input wire logic [31:0]       mem_addr_out,
    input wire logic              mem_rd_valid_in,
    input wire logic              core_valid_out,
    input wire logic [TAG_W-1:0]  core_tag_out,
    input wire logic [DATA_W-1:0] core_data_out,
    input wire logic              core_ready_in,
    input wire logic              irq_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    host_answer_a:
        assert property (host_req_in && !host_ack_out && !host_retry_out
            |=> host_ack_out || host_retry_out)
        else $error("host access not answered");
    free_bound_a:
        assert property (host_ack_out && $past(host_req_in && !host_we_in
            && host_addr_in[15:0] == 16'h0018) |-> host_rdata_out <= QDEPTH)
        else $error("free count above depth");
    retry_write_a:
        assert property (host_retry_out |-> $past(host_req_in && host_we_in))
        else $error("retry on a read");
    window_read_a:
        assert property (host_ack_out && $past(host_req_in && !host_we_in
            && host_addr_in[15:12] == AREA_WINDOW) |-> host_rdata_out == 32'h0)
        else $error("window read returned data");
    fetch_hold_a:
        assert property (mem_rd_req_out && !mem_rd_valid_in
            |=> mem_rd_req_out && $stable(mem_addr_out))
        else $error("fetch request not held");
    fetch_drop_a:
        assert property (mem_rd_req_out && mem_rd_valid_in |=> !mem_rd_req_out)
        else $error("fetch request not dropped");
    core_hold_a:
        assert property (core_valid_out && !core_ready_in |=> core_valid_out
            && $stable(core_tag_out) && $stable(core_data_out))
        else $error("core entry moved in stall");
    irq_hold_a:
        assert property (irq_out && !host_req_in && !$past(host_req_in)
            |=> irq_out)
        else $error("irq fell unasked");
endmodule

// ==== hifdl_mem_model.sv ====
`timescale 1ns/100ps
module hifdl_mem_model
#(
    parameter int SLOW = 5
)
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    // Fetch port
    input  wire logic        req_in,
    input  wire logic [31:0] addr_in,
    output logic             valid_out,
    output logic [31:0]      data_out
);
    logic [31:0] mem [0:31];
    logic        slow;
    int          wait_cnt;

    always @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            valid_out <= 1'b0;
            data_out  <= 32'h0;
            slow      <= 1'b0;
            wait_cnt  = 0;
        end
        else if (!valid_out && req_in && wait_cnt >= (slow ? SLOW : 1))
        begin
            valid_out <= 1'b1;
            data_out  <= mem[addr_in[6:2]];
        end
        else
        begin
            // Idle bus shows changing junk
            valid_out <= 1'b0;
            data_out  <= ~data_out;
            wait_cnt  = req_in && !valid_out ? wait_cnt + 1 : 0;
            slow      <= valid_out ? !slow : slow;
        end
    end
endmodule

// ==== test_host_input_fifo_dma_loader.sv ====
`timescale 1ns/100ps
module test_host_input_fifo_dma_loader
    import hifdl_pkg::*;
;
    logic              clk_sys_in, nrst_in, host_req_in, host_we_in;
    logic [ADDR_W-1:0] host_addr_in;
    logic [DATA_W-1:0] host_wdata_in, host_rdata_out, rd, dt;
    logic              host_ack_out, host_retry_out, rt, rmode;
    logic              mem_rd_req_out, mem_rd_valid_in, irq_out;
    logic [31:0]       mem_addr_out, mem_rd_data_in, core_data_out;
    logic              core_valid_out, core_ready_in;
    logic [TAG_W-1:0]  core_tag_out;
    logic [40:0]       exp_q[$];
    int                err_count, samples_checked, seed, k, n;

    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    hifdl_top #(.QDEPTH(32), .PDEPTH(8)) i_dut (.*);

    hifdl_mem_model i_mem (
        .clk_sys_in, .nrst_in, .req_in(mem_rd_req_out),
        .addr_in(mem_addr_out), .valid_out(mem_rd_valid_in),
        .data_out(mem_rd_data_in));

    // ========
    // Checks and host cycles
    task automatic close_out();
        $display("Mismatches %0d of %0d checks", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic we, input logic [16:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk_sys_in);
        host_req_in   <= 1'b1;
        host_we_in    <= we;
        host_addr_in  <= a;
        host_wdata_in <= d;
        for (i = 0; i < 40 && host_ack_out !== 1'b1
             && host_retry_out !== 1'b1; i++)
            @(posedge clk_sys_in);
        rd = host_rdata_out;
        rt = host_retry_out;
        host_req_in <= 1'b0;
        if (i == 40)
        begin
            err_count++;
            $display("[ERR] %0t host access hung", $time);
            close_out();
        end
    endtask

    task automatic gp(input logic [8:0] tag, input logic [31:0] d);
        acc(1'b1, {1'b0, 4'h8, tag, 3'h0}, d);
        if (rt !== 1'b1)
            exp_q.push_back({tag, d});
    endtask

    task automatic rd_chk(input logic [16:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic drain();
        int i;
        for (i = 0; i < 3000 && exp_q.size() > 0; i++)
            @(posedge clk_sys_in);
        chk(32'(exp_q.size()), 32'h0);
    endtask

    // ========
    // Render core side
    always @(posedge clk_sys_in)
    begin
        core_ready_in <= rmode & 1'($random(seed));
        if (nrst_in && core_valid_out === 1'b1 && core_ready_in === 1'b1)
        begin
            chk(32'(exp_q.size() > 0), 32'h1);
            if (exp_q.size() > 0)
            begin
                chk(32'(core_tag_out), 32'(exp_q[0][40:32]));
                chk(core_data_out, exp_q[0][31:0]);
                void'(exp_q.pop_front());
            end
        end
    end

    // ========
    // Main sequence
    initial
    begin
        seed = 86;
        {err_count, samples_checked} = 0;
        {nrst_in, host_req_in, host_we_in, core_ready_in, rmode} = 0;
        host_addr_in  = '0;
        host_wdata_in = '0;
        repeat (8) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        rd_chk(17'h00018, 32'h20);
        rd_chk(17'h00030, 32'h0);
        rd_chk(17'h00068, 32'h0);
        rd_chk(17'h00ff0, 32'h0);
        for (k = 0; k < 5; k++)
            gp(9'(k), $random(seed));
        repeat (6) @(posedge clk_sys_in);
        rd_chk(17'h00018, 32'h1c);
        acc(1'b1, 17'h00068, 32'h1);
        rd_chk(17'h00068, 32'h1);
        for (k = 5; k < 45 && rt !== 1'b1; k++)
            gp(9'(k), $random(seed));
        chk(32'(rt), 32'h1);
        rd_chk(17'h00018, 32'h0);
        acc(1'b1, 17'h00068, 32'h0);
        acc(1'b1, 17'h08010, 32'hdeadbeef);
        chk(32'(rt), 32'h0);
        acc(1'b1, 17'h00068, 32'h1);
        dt = $random(seed);
        rmode <= 1'b1;
        n = 0;
        do
            gp(9'h1ff, dt);
        while (rt !== 1'b0 && ++n < 30);
        chk(32'(rt), 32'h0);
        drain();
        rd_chk(17'h00018, 32'h20);
        dt = $random(seed);
        acc(1'b1, 17'h02000, 32'h00014010);
        acc(1'b1, 17'h02ffc, dt);
        exp_q.push_back({9'h010, dt});
        acc(1'b1, 17'h02004, ~dt);
        exp_q.push_back({9'h011, ~dt});
        rd_chk(17'h02000, 32'h0);
        drain();
        // Indexed then hold group; rest is junk
        for (k = 0; k < 32; k++)
            i_mem.mem[k] = $random(seed);
        i_mem.mem[0] = 32'h003280f0;
        i_mem.mem[4] = 32'h00010005;
        exp_q.push_back({9'h0f1, i_mem.mem[1]});
        exp_q.push_back({9'h0f4, i_mem.mem[2]});
        exp_q.push_back({9'h0f5, i_mem.mem[3]});
        exp_q.push_back({9'h005, i_mem.mem[5]});
        exp_q.push_back({9'h005, i_mem.mem[6]});
        acc(1'b1, 17'h00008, 32'h1);
        acc(1'b1, 17'h00028, 32'h0);
        acc(1'b1, 17'h00030, 32'h7);
        acc(1'b1, 17'h00028, 32'h40);
        n = 0;
        do
            acc(1'b0, 17'h00030, 32'h0);
        while (rd !== 32'h0 && ++n < 60);
        chk(rd, 32'h0);
        repeat (2) @(posedge clk_sys_in);
        chk(32'(irq_out), 32'h1);
        drain();
        acc(1'b1, 17'h00010, 32'h1);
        repeat (2) @(posedge clk_sys_in);
        chk(32'(irq_out), 32'h0);
        close_out();
    end
endmodule

bind hifdl_top hifdl_checker #(.QDEPTH(QDEPTH)) i_chk (.*);
